// [verilog/fecp_coding_path.sv]
// 100 mb/s coding path between the mii and the mlt-3 line
// -----------------------------------------------------------------
// Summary of operation
// [RL1] mii nibbles serialised at the bit rate
// [RL2] 4b/5b coding first, then scrambling
// [RL3] nrz to nrzi, then mlt-3 symbols out
// [RL4] scrambler is an 11-bit lfsr
// [RL5] sequence repeats only after 2047 bits
// [RL6] descrambler runs the same sequence
// [RL7] received mlt-3 turned back into nrzi
// [RL8] bit clock recovered from nrzi edges
// [RL9] recovered clock samples nrzi into nrz
// [RL10] descramble first, then 4b/5b decode
// [RL11] decoded nibbles delivered on the mii
// [RL12] x11+x9+1 taps, descrambler locks on idle
// [RL13] j/k start, t/r end, idle between frames
// -----------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "fecp_map.svh"

module fecp_coding_path (
    input  wire logic       mclk,     // mii side clock
    input  wire logic       rstn,     // async reset, low active
    input  wire logic       lineClk,  // line side clock
    input  wire logic       txEn,     // mac frame in progress
    input  wire logic [3:0] txd,      // mac transmit nibble
    output logic            txReady,  // nibble taken this cycle
    output logic            rxDv,     // receive frame in progress
    output logic [3:0]      rxd,      // receive nibble
    output logic            rxStb,    // rxd holds a new nibble
    output logic            rxEr,     // code or framing error
    input  wire logic       rxStall,  // mac holds off delivery
    output logic [1:0]      txSym,    // mlt-3 level to driver
    input  wire logic [1:0] rxSymIn,  // mlt-3 level from slicer
    output logic            rxLocked  // descrambler in step
);
    // -------------------------------------------------------------
    // line side reset release
    // -------------------------------------------------------------
    logic lrst1_r;
    logic lineRstn_r;

    always_ff @(posedge lineClk or negedge rstn) begin
        if (!rstn) begin
            lrst1_r    <= 1'b0;
            lineRstn_r <= 1'b0;
        end else begin
            lrst1_r    <= 1'b1;
            lineRstn_r <= lrst1_r;
        end
    end

    // 4b/5b lookups
    function automatic logic [4:0] enc5(input logic [3:0] n);
        logic [79:0] tbl;
        tbl = `FECP_4B5B_TABLE;
        return tbl[n * 5 +: 5];
    endfunction

    function automatic logic [4:0] dec5(input logic [4:0] g);
        logic [4:0] res;
        res = '0;
        for (int i = 0; i < 16; i++) begin
            if (enc5(4'(i)) == g) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    // -------------------------------------------------------------
    // transmit, mii side
    // -------------------------------------------------------------
    logic [1:0]           txCnt_r;
    logic                 txInFrame_r;
    logic                 txWValid;
    logic                 txWReady;
    fecp_pkg::fecp_entry_t txWData;

    // first nibble becomes the start marker, second is swallowed
    always_comb begin
        txWValid     = txEn ? (txCnt_r != `FECP_SSD_SKIP) : txInFrame_r;
        txWData.nib  = txd;
        txWData.kind = !txEn ? fecp_pkg::FECP_ESD :
                       (txCnt_r == '0) ? fecp_pkg::FECP_SSD :
                       fecp_pkg::FECP_DATA; // [RL13]
        txReady      = !txEn || (txCnt_r == `FECP_SSD_SKIP) || txWReady;
    end

    // nibble count within the frame
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            txCnt_r <= '0;
        end else if (!txEn) begin
            txCnt_r <= '0;
        end else if (txReady && txCnt_r != `FECP_CNT_SAT) begin
            txCnt_r <= txCnt_r + 2'h1;
        end
    end

    // end marker owed until the buffer takes it
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            txInFrame_r <= 1'b0;
        end else if (txEn) begin
            txInFrame_r <= 1'b1;
        end else if (txWReady) begin
            txInFrame_r <= 1'b0;
        end
    end

    fecp_pkg::fecp_entry_t txRData;
    logic                  txRValid;
    logic                  txRReady;

    fecp_cdc_fifo #(.W($bits(fecp_pkg::fecp_entry_t)), .AW(1)) uTxBuf (
        .wClk   (mclk),
        .wRstn  (rstn),
        .wData  (txWData),
        .wValid (txWValid),
        .wReady (txWReady),
        .rClk   (lineClk),
        .rRstn  (lineRstn_r),
        .rData  (txRData),
        .rValid (txRValid),
        .rReady (txRReady)
    );

    // -------------------------------------------------------------
    // transmit, line side
    // -------------------------------------------------------------
    logic [1:0]           txPh_r;
    logic [2:0]           txIdx_r;
    logic [4:0]           txSh_r;
    logic [4:0]           txGrp_nxt;
    fecp_pkg::fecp_pend_t txPend_r;
    logic [10:0]          txLfsr_r;
    logic                 txNrzi_r;
    logic                 txNrzi_nxt;
    logic [1:0]           txMlt_r;
    logic [1:0]           txSym_r;
    logic                 bitStb;
    logic                 grpLoad;
    logic                 txKey;
    logic                 scrBit;

    assign bitStb  = txPh_r == `FECP_OVS_LAST; // [RL1]
    assign grpLoad = bitStb && txIdx_r == `FECP_BIT_LAST;
    assign txRReady = grpLoad && txPend_r == fecp_pkg::FECP_PEND_NONE;
    assign txKey   = txLfsr_r[`FECP_TAP_A] ^ txLfsr_r[`FECP_TAP_B]; // [RL12]
    assign scrBit  = txSh_r[4] ^ txKey; // [RL2]
    assign txNrzi_nxt = txNrzi_r ^ scrBit; // [RL3]
    assign txSym   = txSym_r;

    // next code group: owed half, buffered entry or idle
    always_comb begin
        txGrp_nxt = `FECP_CODE_IDLE; // [RL13]
        if (txPend_r == fecp_pkg::FECP_PEND_K) begin
            txGrp_nxt = `FECP_CODE_K;
        end else if (txPend_r == fecp_pkg::FECP_PEND_R) begin
            txGrp_nxt = `FECP_CODE_R;
        end else if (txRValid) begin
            case (txRData.kind)
                fecp_pkg::FECP_SSD:  txGrp_nxt = `FECP_CODE_J;
                fecp_pkg::FECP_DATA: txGrp_nxt = enc5(txRData.nib); // [RL2]
                fecp_pkg::FECP_ESD:  txGrp_nxt = `FECP_CODE_T;
                default:             txGrp_nxt = `FECP_CODE_IDLE;
            endcase
        end
    end

    // bit phase within the line clock
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            txPh_r <= '0;
        end else begin
            txPh_r <= txPh_r + 2'h1;
        end
    end

    // serialiser, one code group every five bits
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            txIdx_r <= '0;
            txSh_r  <= `FECP_CODE_IDLE;
        end else if (grpLoad) begin
            txIdx_r <= '0;
            txSh_r  <= txGrp_nxt;
        end else if (bitStb) begin
            txIdx_r <= txIdx_r + 3'h1; // [RL1]
            txSh_r  <= {txSh_r[3:0], 1'b0};
        end
    end

    // second half of j/k and t/r
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            txPend_r <= fecp_pkg::FECP_PEND_NONE;
        end else if (grpLoad) begin
            case (txPend_r)
                fecp_pkg::FECP_PEND_NONE: begin
                    if (txRValid && txRData.kind == fecp_pkg::FECP_SSD) begin
                        txPend_r <= fecp_pkg::FECP_PEND_K; // [RL13]
                    end else if (txRValid &&
                                 txRData.kind == fecp_pkg::FECP_ESD) begin
                        txPend_r <= fecp_pkg::FECP_PEND_R;
                    end
                end
                default: txPend_r <= fecp_pkg::FECP_PEND_NONE;
            endcase
        end
    end

    // scrambler, nrzi and mlt-3 per bit
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            txLfsr_r <= `FECP_SCR_SEED; // [RL5]
            txNrzi_r <= 1'b0;
            txMlt_r  <= '0;
            txSym_r  <= `FECP_MLT_ZERO;
        end else if (bitStb) begin
            txLfsr_r <= {txLfsr_r[9:0], txKey}; // [RL4]
            txNrzi_r <= txNrzi_nxt;
            if (txNrzi_nxt != txNrzi_r) begin
                txMlt_r <= txMlt_r + 2'h1; // [RL3]
                case (txMlt_r)
                    2'h0:    txSym_r <= `FECP_MLT_POS;
                    2'h2:    txSym_r <= `FECP_MLT_NEG;
                    default: txSym_r <= `FECP_MLT_ZERO;
                endcase
            end
        end
    end

    // -------------------------------------------------------------
    // receive, line side
    // -------------------------------------------------------------
    logic [1:0]  rxS1_r;
    logic [1:0]  rxS2_r;
    logic        rxNrziD_r;
    logic        rxLast_r;
    logic [1:0]  rxPh_r;
    logic [10:0] rxLfsr_r;
    logic [3:0]  rxLockCnt_r;
    logic        rxLocked_r;
    logic [8:0]  rxWin_r;
    logic        rxInFrame_r;
    logic [2:0]  rxIdx_r;
    logic        rxWValid_r;
    fecp_pkg::fecp_entry_t rxWData_r;
    logic        rxNrzi;
    logic        rxEdge;
    logic        rxSample;
    logic        rxBit;
    logic        rxKey;
    logic        rxPlain;
    logic [4:0]  rxGrp;
    logic [4:0]  rxDec;
    logic        rxGrpEnd;

    assign rxNrzi   = rxS2_r != `FECP_MLT_ZERO; // [RL7]
    assign rxEdge   = rxNrzi != rxNrziD_r;
    assign rxSample = rxPh_r == `FECP_RX_SAMPLE; // [RL8]
    assign rxBit    = rxNrzi ^ rxLast_r; // [RL9]
    assign rxKey    = rxLfsr_r[`FECP_TAP_A] ^ rxLfsr_r[`FECP_TAP_B];
    assign rxPlain  = rxBit ^ rxKey; // [RL6]
    assign rxGrp    = {rxWin_r[3:0], rxPlain};
    assign rxDec    = dec5(rxGrp); // [RL10]
    assign rxGrpEnd = rxSample && rxInFrame_r &&
                      rxIdx_r == `FECP_BIT_LAST;
    assign rxLocked = rxLocked_r;

    // slicer level through two flops
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            rxS1_r <= `FECP_MLT_ZERO;
            rxS2_r <= `FECP_MLT_ZERO;
        end else begin
            rxS1_r <= rxSymIn;
            rxS2_r <= rxS1_r;
        end
    end

    // bit phase pulled to each nrzi edge
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            rxNrziD_r <= 1'b0;
            rxPh_r    <= '0;
            rxLast_r  <= 1'b0;
        end else begin
            rxNrziD_r <= rxNrzi;
            rxPh_r    <= rxEdge ? '0 : rxPh_r + 2'h1; // [RL8]
            if (rxSample) begin
                rxLast_r <= rxNrzi; // [RL9]
            end
        end
    end

    // descrambler: loads key from idle until in step
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            rxLfsr_r    <= `FECP_SCR_SEED;
            rxLockCnt_r <= '0;
            rxLocked_r  <= 1'b0;
        end else if (rxGrpEnd && !rxDec[4] && rxGrp != `FECP_CODE_T) begin
            rxLockCnt_r <= '0;
            rxLocked_r  <= 1'b0;
        end else if (rxSample && !rxLocked_r) begin
            rxLfsr_r    <= {rxLfsr_r[9:0], ~rxBit}; // [RL12]
            rxLockCnt_r <= rxLockCnt_r + 4'h1;
            rxLocked_r  <= rxLockCnt_r == `FECP_LOCK_LAST;
        end else if (rxSample) begin
            rxLfsr_r <= {rxLfsr_r[9:0], rxKey}; // [RL6]
        end
    end

    // code group framing and decode
    always_ff @(posedge lineClk or negedge lineRstn_r) begin
        if (!lineRstn_r) begin
            rxWin_r     <= '0;
            rxInFrame_r <= 1'b0;
            rxIdx_r     <= '0;
            rxWValid_r  <= 1'b0;
            rxWData_r   <= '0;
        end else begin
            rxWValid_r <= 1'b0;
            if (rxSample) begin
                rxWin_r <= {rxWin_r[7:0], rxPlain};
                rxIdx_r <= rxIdx_r + 3'h1;
            end
            if (rxSample && rxLocked_r && !rxInFrame_r &&
                {rxWin_r, rxPlain} == {`FECP_CODE_J, `FECP_CODE_K}) begin
                rxInFrame_r    <= 1'b1; // [RL10]
                rxIdx_r        <= '0;
                rxWValid_r     <= 1'b1;
                rxWData_r.kind <= fecp_pkg::FECP_SSD;
                rxWData_r.nib  <= `FECP_PREAMBLE;
            end else if (rxGrpEnd) begin
                rxIdx_r        <= '0;
                rxWValid_r     <= 1'b1;
                rxWData_r.nib  <= rxDec[3:0];
                rxWData_r.kind <= fecp_pkg::FECP_DATA;
                if (!rxDec[4]) begin
                    rxInFrame_r    <= 1'b0;
                    rxWData_r.kind <= (rxGrp == `FECP_CODE_T) ?
                                      fecp_pkg::FECP_ESD :
                                      fecp_pkg::FECP_ERR;
                end
            end
        end
    end

    fecp_pkg::fecp_entry_t rxRData;
    logic                  rxRValid;
    logic                  rxPop;

    fecp_cdc_fifo #(.W($bits(fecp_pkg::fecp_entry_t)), .AW(1)) uRxBuf (
        .wClk   (lineClk),
        .wRstn  (lineRstn_r),
        .wData  (rxWData_r),
        .wValid (rxWValid_r),
        .wReady (),
        .rClk   (mclk),
        .rRstn  (rstn),
        .rData  (rxRData),
        .rValid (rxRValid),
        .rReady (!rxStall)
    );

    // -------------------------------------------------------------
    // receive, mii side
    // -------------------------------------------------------------
    logic       rxDv_r;
    logic [3:0] rxd_r;
    logic       rxStb_r;
    logic       rxEr_r;

    assign rxPop = rxRValid && !rxStall;
    assign rxDv  = rxDv_r;
    assign rxd   = rxd_r;
    assign rxStb = rxStb_r;
    assign rxEr  = rxEr_r;

    // one entry per cycle onto the mii
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rxDv_r  <= 1'b0;
            rxd_r   <= '0;
            rxStb_r <= 1'b0;
            rxEr_r  <= 1'b0;
        end else begin
            rxStb_r <= rxPop && rxRData.kind != fecp_pkg::FECP_ESD;
            rxEr_r  <= rxPop && rxRData.kind == fecp_pkg::FECP_ERR;
            if (rxPop) begin
                rxd_r  <= rxRData.nib; // [RL11]
                rxDv_r <= rxRData.kind == fecp_pkg::FECP_SSD ||
                          rxRData.kind == fecp_pkg::FECP_DATA;
            end
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    property p_bit_rate;
        @(posedge lineClk) disable iff (!lineRstn_r)
        bitStb |=> !bitStb [*3] ##1 bitStb;
    endproperty
    a_bit_rate: assert property (p_bit_rate) // [RL1]
        else $error("bit strobe spacing wrong");

    property p_idle_fill;
        @(posedge lineClk) disable iff (!lineRstn_r)
        (grpLoad && txPend_r == fecp_pkg::FECP_PEND_NONE && !txRValid)
        |=> txSh_r == `FECP_CODE_IDLE;
    endproperty
    a_idle_fill: assert property (p_idle_fill) // [RL13]
        else $error("idle not sent between frames");

    property p_start_pair;
        @(posedge lineClk) disable iff (!lineRstn_r)
        (txRReady && txRValid && txRData.kind == fecp_pkg::FECP_SSD)
        |=> txSh_r == `FECP_CODE_J ##20 txSh_r == `FECP_CODE_K;
    endproperty
    a_start_pair: assert property (p_start_pair) // [RL13]
        else $error("start marker not sent as j then k");

    property p_mlt_step;
        @(posedge lineClk) disable iff (!lineRstn_r)
        (bitStb && scrBit) |=> txSym_r != $past(txSym_r);
    endproperty
    a_mlt_step: assert property (p_mlt_step) // [RL3]
        else $error("mlt-3 level did not move on a one");

    property p_lfsr_live;
        @(posedge lineClk) disable iff (!lineRstn_r)
        bitStb |=> txLfsr_r != '0 && txLfsr_r != $past(txLfsr_r);
    endproperty
    a_lfsr_live: assert property (p_lfsr_live) // [RL5]
        else $error("scrambler register stuck");

    property p_edge_resync;
        @(posedge lineClk) disable iff (!lineRstn_r)
        rxEdge ##1 !rxEdge [*2] |=> rxSample;
    endproperty
    a_edge_resync: assert property (p_edge_resync) // [RL8]
        else $error("sample not centred after edge");

    property p_frame_locked;
        @(posedge lineClk) disable iff (!lineRstn_r)
        $rose(rxInFrame_r) |-> $past(rxLocked_r) && rxWValid_r;
    endproperty
    a_frame_locked: assert property (p_frame_locked) // [RL10]
        else $error("frame started without descrambler lock");

    property p_rx_end;
        @(posedge mclk) disable iff (!rstn)
        (rxPop && rxRData.kind == fecp_pkg::FECP_ESD) |=> !rxDv && !rxStb;
    endproperty
    a_rx_end: assert property (p_rx_end) // [RL11]
        else $error("receive valid not dropped at end");

endmodule

`default_nettype wire

// [common/fecp_map.svh]
// constants of the fast ethernet coding path
`ifndef FECP_MAP_SVH
`define FECP_MAP_SVH

// -----------------------------------------------------------------
// line timing: line clock cycles per code bit, code bits per group
// -----------------------------------------------------------------
`define FECP_OVS_LAST   2'h3
`define FECP_RX_SAMPLE  2'h2
`define FECP_BIT_LAST   3'h4

// -----------------------------------------------------------------
// 5-bit code groups, first bit sent is the msb
// -----------------------------------------------------------------
`define FECP_CODE_J     5'h18
`define FECP_CODE_K     5'h11
`define FECP_CODE_T     5'h0D
`define FECP_CODE_R     5'h07
`define FECP_CODE_IDLE  5'h1F
`define FECP_4B5B_TABLE 80'hEF37ABDA727B96AAD13E

// -----------------------------------------------------------------
// scrambler
// -----------------------------------------------------------------
`define FECP_SCR_SEED   11'h7FF
`define FECP_TAP_A      10
`define FECP_TAP_B      8
`define FECP_LOCK_LAST  4'hA

// -----------------------------------------------------------------
// mlt-3 levels and mii side
// -----------------------------------------------------------------
`define FECP_MLT_ZERO   2'h0
`define FECP_MLT_POS    2'h1
`define FECP_MLT_NEG    2'h3
`define FECP_PREAMBLE   4'h5
`define FECP_SSD_SKIP   2'h1
`define FECP_CNT_SAT    2'h2

`endif

// [common/fecp_pkg.sv]
// types of the fast ethernet coding path
package fecp_pkg;

    // kind of a buffered nibble
    typedef enum logic [1:0] {
        FECP_DATA,
        FECP_SSD,
        FECP_ESD,
        FECP_ERR
    } fecp_kind_t;

    // one buffered entry
    typedef struct packed {
        fecp_kind_t kind;
        logic [3:0] nib;
    } fecp_entry_t;

    // second code group still owed by the transmitter
    typedef enum logic [1:0] {
        FECP_PEND_NONE,
        FECP_PEND_K,
        FECP_PEND_R
    } fecp_pend_t;

endpackage

// [verilog/fecp_cdc_fifo.sv]
// two-clock buffer with gray coded pointers
`timescale 1ns/1ns
`default_nettype none

module fecp_cdc_fifo #(
    parameter int W  = 6,
    parameter int AW = 1
) (
    input  wire logic         wClk,   // write side clock
    input  wire logic         wRstn,  // write side reset, low active
    input  wire logic [W-1:0] wData,  // entry to store
    input  wire logic         wValid, // entry offered
    output logic              wReady, // room for an entry
    input  wire logic         rClk,   // read side clock
    input  wire logic         rRstn,  // read side reset, low active
    output logic [W-1:0]      rData,  // oldest entry
    output logic              rValid, // an entry is waiting
    input  wire logic         rReady  // reader takes the entry
);
    localparam logic [AW:0] DEPTH = (AW + 1)'(1) << AW;

    logic [W-1:0] mem [2**AW];
    logic [AW:0]  wBin_r;
    logic [AW:0]  rBin_r;
    logic [AW:0]  wGray_r;
    logic [AW:0]  rGray_r;
    logic [AW:0]  rGrayS1_r;
    logic [AW:0]  rGrayS2_r;
    logic [AW:0]  wGrayS1_r;
    logic [AW:0]  wGrayS2_r;
    logic [AW:0]  wBin_nxt;
    logic [AW:0]  rBin_nxt;

    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    // full and empty from the crossed pointers
    assign wReady   = (wBin_r - g2b(rGrayS2_r)) != DEPTH;
    assign rValid   = wGrayS2_r != rGray_r;
    assign rData    = mem[rBin_r[AW-1:0]];
    assign wBin_nxt = wBin_r + (AW + 1)'(wValid & wReady);
    assign rBin_nxt = rBin_r + (AW + 1)'(rValid & rReady);

    // write side: store and advance
    always_ff @(posedge wClk) begin
        if (wValid && wReady) begin
            mem[wBin_r[AW-1:0]] <= wData;
        end
    end

    always_ff @(posedge wClk or negedge wRstn) begin
        if (!wRstn) begin
            wBin_r  <= '0;
            wGray_r <= '0;
        end else begin
            wBin_r  <= wBin_nxt;
            wGray_r <= wBin_nxt ^ (wBin_nxt >> 1);
        end
    end

    // read pointer crossing into the write side
    always_ff @(posedge wClk or negedge wRstn) begin
        if (!wRstn) begin
            rGrayS1_r <= '0;
            rGrayS2_r <= '0;
        end else begin
            rGrayS1_r <= rGray_r;
            rGrayS2_r <= rGrayS1_r;
        end
    end

    // read side: advance
    always_ff @(posedge rClk or negedge rRstn) begin
        if (!rRstn) begin
            rBin_r  <= '0;
            rGray_r <= '0;
        end else begin
            rBin_r  <= rBin_nxt;
            rGray_r <= rBin_nxt ^ (rBin_nxt >> 1);
        end
    end

    // write pointer crossing into the read side
    always_ff @(posedge rClk or negedge rRstn) begin
        if (!rRstn) begin
            wGrayS1_r <= '0;
            wGrayS2_r <= '0;
        end else begin
            wGrayS1_r <= wGray_r;
            wGrayS2_r <= wGrayS1_r;
        end
    end

endmodule

`default_nettype wire

// [verification/fecp_line_model.sv]
// line front end model looping the mlt-3 output back to the slicer
`timescale 1ns/1ns
`default_nettype none

module fecp_line_model (
    input  wire logic       lineClk, // line side clock
    input  wire logic [1:0] txSym,   // level from the driver
    output logic [1:0]      rxSymIn  // level to the slicer
);
    // one line clock of cable delay, levels kept on the bit grid
    always @(posedge lineClk) begin
        rxSymIn <= txSym;
    end
endmodule

`default_nettype wire

// [verification/tb_fecp_coding_path.sv]
// self-checking bench: mac side driven, line looped back
`timescale 1ns/1ns
`default_nettype none

module tb_fecp_coding_path;
    logic       mclk = 1'b0, lineClk = 1'b0, rstn = 1'b0;
    logic       txEn = 1'b0, rxStall = 1'b0;
    logic [3:0] txd = 4'h0;
    logic       txReady, rxDv, rxStb, rxEr, rxLocked;
    logic [3:0] rxd;
    logic [1:0] txSym, rxSymIn;
    int         fail_count = 0, check_count = 0, waits = 0;
    logic [3:0] got[$];

    // clocks, unrelated in phase
    always #25 mclk = ~mclk;
    always #16 lineClk = ~lineClk;

    fecp_coding_path dut (.mclk(mclk), .rstn(rstn), .lineClk(lineClk),
        .txEn(txEn), .txd(txd), .txReady(txReady), .rxDv(rxDv),
        .rxd(rxd), .rxStb(rxStb), .rxEr(rxEr), .rxStall(rxStall),
        .txSym(txSym), .rxSymIn(rxSymIn), .rxLocked(rxLocked));
    fecp_line_model line (.lineClk(lineClk), .txSym(txSym),
        .rxSymIn(rxSymIn));

    task automatic chk(input string nm, input logic [3:0] e, s);
        check_count++;
        if (e !== s) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // counts and flags compared as whole numbers
    task automatic chk_cnt(input string nm, input int e, s);
        check_count++;
        if (e != s) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    task automatic summarize;
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // collect delivered nibbles mid-cycle, flag errors and illegal levels
    always @(negedge mclk) begin
        if (rxStb === 1'b1) begin
            got.push_back(rxd);
            chk("rxDv", 4'h1, {3'h0, rxDv});
        end
        if (rxEr === 1'b1) chk("rxEr", 4'h0, 4'h1);
    end
    always @(negedge lineClk) begin
        if (rstn) chk("txSymLegal", 4'h1, {3'h0, txSym !== 2'h2});
    end

    // offer one nibble and hold it until taken
    task automatic send(input logic [3:0] n);
        txEn = 1'b1;
        txd  = n;
        #1;
        while (txReady !== 1'b1) begin
            waits++;
            @(posedge mclk);
            #3;
        end
        @(posedge mclk);
        #2;
    endtask

    // send a frame, stall the mac, compare what comes back
    task automatic xfer(input logic [3:0] n[$], input int stall);
        logic [3:0] e[$];
        int         i;
        got.delete();
        waits = 0;
        e.push_back(4'h5);
        for (i = 2; i < n.size(); i++) e.push_back(n[i]);
        for (i = 0; i < n.size(); i++) send(n[i]);
        txEn    = 1'b0;
        // two-entry buffer must have pushed back at least once
        chk_cnt("txReadyHeld", 1, int'(waits > 0));
        rxStall = (stall > 0);
        repeat (stall) @(posedge mclk);
        #2 rxStall = 1'b0;
        i = 0;
        while ((got.size() < e.size() || rxDv !== 1'b0) && i < 4000) begin
            @(posedge mclk);
            i++;
        end
        chk_cnt("rxDone", 1, int'(i < 4000));
        chk_cnt("count", e.size(), got.size());
        for (i = 0; i < e.size() && i < got.size(); i++)
            chk("rxd", e[i], got[i]);
        chk("rxLockedKept", 4'h1, {3'h0, rxLocked});
        repeat (20) @(posedge mclk);
        #2;
    endtask

    task automatic test_lock;
        int i;
        i = 0;
        while (rxLocked !== 1'b1 && i < 2000) begin
            @(posedge mclk);
            i++;
        end
        #2;
        chk("rxLocked", 4'h1, {3'h0, rxLocked});
    endtask

    task automatic test_frame;
        xfer('{4'h5, 4'h5, 4'h5, 4'hD, 4'hA, 4'hB, 4'hC}, 20);
    endtask

    task automatic test_edges;
        xfer('{4'h5, 4'h5, 4'h0, 4'hF, 4'h0}, 0);
    endtask

    // watchdog
    initial begin
        #400000;
        fail_count++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        #2 rstn = 1'b1;
        test_lock();
        test_frame();
        test_edges();
        summarize();
    end
endmodule

`default_nettype wire
